/* rtl/apts_defines.vh */
`ifndef APTS_DEFINES_VH
`define APTS_DEFINES_VH

// Register indices on the plain register port
`define APTS_ADDR_W          4
`define APTS_REG_CTRL2       4'h0
`define APTS_REG_STATUS      4'h1
`define APTS_REG_MASK        4'h2
`define APTS_REG_PAIR5       4'h3

// Control register 2 fields
`define APTS_SRC5_HI         12
`define APTS_SRC5_LO         8
`define APTS_PAIR4_INTERRUPT_ENABLE_BIT      7
`define APTS_PAIR4_PENDING_BIT       6
`define APTS_PAIR4_SOFTWARE_TRIGGER_BIT      5
`define APTS_SRC4_HI         4
`define APTS_SRC4_LO         0
`define APTS_CTRL2_RESET     16'h0000

// Pair 5 status register fields (own register)
`define APTS_PEND5_BIT       0
`define APTS_SWTRG5_BIT      1

// Interrupt status bits
`define APTS_IRQ_DONE4       0
`define APTS_IRQ_DONE5       1
`define APTS_IRQ_W           2
`define APTS_IRQ_RESET       2'h0

// Trigger source codes
`define APTS_SRC_OFF         5'h00
`define APTS_SRC_SW_IND      5'h01
`define APTS_SRC_SW_GLB      5'h02
`define APTS_SRC_SPECIAL     5'h03
`define APTS_SRC_PRI_LO      5'h04
`define APTS_SRC_PRI_HI      5'h07
`define APTS_SRC_TMR1        5'h0c
`define APTS_SRC_SEC_LO      5'h0e
`define APTS_SRC_SEC_HI      5'h11
`define APTS_SRC_CL_LO       5'h17
`define APTS_SRC_CL_HI       5'h1a
`define APTS_SRC_TMR2        5'h1f

// Sequencer states
`define APTS_ST_IDLE         2'b00
`define APTS_ST_BUSY4        2'b01
`define APTS_ST_BUSY5        2'b10

`endif

/* rtl/apts_top.v */
`timescale 1ns/1ns
`default_nettype none
`include "apts_defines.vh"

module apts_top (
  input  wire                    sys_clk_i,
  input  wire                    resetn_i,
  input  wire [`APTS_ADDR_W-1:0] addr_i,
  input  wire [15:0]             wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [15:0]             rdata_o,
  input  wire                    special_trig_i,
  input  wire [3:0]              pwm_primary_i,
  input  wire [3:0]              pwm_secondary_i,
  input  wire [3:0]              pwm_climit_i,
  input  wire                    tmr1_match_i,
  input  wire                    tmr2_match_i,
  input  wire                    conv_busy_i,
  input  wire                    conv_done_i,
  output reg                     conv_start4_o,
  output reg                     conv_start5_o,
  output reg                     pair4_pending_o,
  output reg                     pair5_pending_o,
  output reg                     irq_o
);

  reg  [4:0]              pair4_trigger_source_ff;
  reg  [4:0]              pair5_trigger_source_ff;
  reg                     pair4_interrupt_enable_ff;
  reg                     pair4_software_trigger_ff;
  reg                     pair5_software_trigger_ff;
  reg                     pair4_pending_ff;
  reg                     pair5_pending_ff;
  reg  [1:0]              state_ff;
  reg  [`APTS_IRQ_W-1:0]  irq_status_ff;
  reg  [`APTS_IRQ_W-1:0]  irq_mask_ff;
  reg  [1:0]              nxt_state;
  reg                     nxt_start4;
  reg                     nxt_start5;
  reg  [15:0]             nxt_rdata;
  wire                    trig4;
  wire                    trig5;
  wire                    done4;
  wire                    done5;
  wire [`APTS_IRQ_W-1:0]  irq_events;
  wire [`APTS_IRQ_W-1:0]  nxt_irq_status;

  localparam [1:0]  ST_IDLE   = `APTS_ST_IDLE;
  localparam [1:0]  ST_BUSY4  = `APTS_ST_BUSY4;
  localparam [1:0]  ST_BUSY5  = `APTS_ST_BUSY5;
  localparam [15:0] CTRL2_RST = `APTS_CTRL2_RESET;

  wire wr_ctrl2  = wr_i && addr_i == `APTS_REG_CTRL2;
  wire wr_status = wr_i && addr_i == `APTS_REG_STATUS;
  wire wr_mask   = wr_i && addr_i == `APTS_REG_MASK;
  wire wr_pair5  = wr_i && addr_i == `APTS_REG_PAIR5;

  apts_trig_mux u_mux4 (
    .sys_clk_i       (sys_clk_i),
    .resetn_i        (resetn_i),
    .source_i        (pair4_trigger_source_ff),
    .sw_trig_i       (pair4_software_trigger_ff),
    .special_trig_i  (special_trig_i),
    .pwm_primary_i   (pwm_primary_i),
    .pwm_secondary_i (pwm_secondary_i),
    .pwm_climit_i    (pwm_climit_i),
    .tmr1_match_i    (tmr1_match_i),
    .tmr2_match_i    (tmr2_match_i),
    .trig_o          (trig4)
  );

  apts_trig_mux u_mux5 (
    .sys_clk_i       (sys_clk_i),
    .resetn_i        (resetn_i),
    .source_i        (pair5_trigger_source_ff),
    .sw_trig_i       (pair5_software_trigger_ff),
    .special_trig_i  (special_trig_i),
    .pwm_primary_i   (pwm_primary_i),
    .pwm_secondary_i (pwm_secondary_i),
    .pwm_climit_i    (pwm_climit_i),
    .tmr1_match_i    (tmr1_match_i),
    .tmr2_match_i    (tmr2_match_i),
    .trig_o          (trig5)
  );

  // Control fields and software triggers
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pair4_trigger_source_ff   <= CTRL2_RST[`APTS_SRC4_HI:`APTS_SRC4_LO];
      pair5_trigger_source_ff   <= CTRL2_RST[`APTS_SRC5_HI:`APTS_SRC5_LO];
      pair4_interrupt_enable_ff <= CTRL2_RST[`APTS_PAIR4_INTERRUPT_ENABLE_BIT];
      pair4_software_trigger_ff <= CTRL2_RST[`APTS_PAIR4_SOFTWARE_TRIGGER_BIT];
      pair5_software_trigger_ff <= 1'b0;
      irq_mask_ff               <= `APTS_IRQ_RESET;
    end else begin
      if (wr_ctrl2) begin
        pair5_trigger_source_ff   <= wdata_i[`APTS_SRC5_HI:`APTS_SRC5_LO];
        pair4_trigger_source_ff   <= wdata_i[`APTS_SRC4_HI:`APTS_SRC4_LO];
        pair4_interrupt_enable_ff <= wdata_i[`APTS_PAIR4_INTERRUPT_ENABLE_BIT];
      end
      // Pending set clears the trigger; a new write of one wins
      if (wr_ctrl2 && wdata_i[`APTS_PAIR4_SOFTWARE_TRIGGER_BIT]) begin
        pair4_software_trigger_ff <= 1'b1;
      end else if (trig4) begin
        pair4_software_trigger_ff <= 1'b0;
      end
      if (wr_pair5 && wdata_i[`APTS_SWTRG5_BIT]) begin
        pair5_software_trigger_ff <= 1'b1;
      end else if (trig5) begin
        pair5_software_trigger_ff <= 1'b0;
      end
      if (wr_mask) begin
        irq_mask_ff <= wdata_i[`APTS_IRQ_W-1:0];
      end
    end
  end

  // Sequencer: one conversion at a time, pair 4 first
  assign done4 = state_ff == ST_BUSY4 && conv_done_i;
  assign done5 = state_ff == ST_BUSY5 && conv_done_i;

  always @* begin
    nxt_state  = state_ff;
    nxt_start4 = 1'b0;
    nxt_start5 = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (!conv_busy_i) begin
          if (pair4_pending_ff) begin
            nxt_state  = ST_BUSY4;
            nxt_start4 = 1'b1;
          end else if (pair5_pending_ff) begin
            nxt_state  = ST_BUSY5;
            nxt_start5 = 1'b1;
          end
        end
      end
      ST_BUSY4: begin
        if (conv_done_i) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_BUSY5: begin
        if (conv_done_i) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff         <= ST_IDLE;
      pair4_pending_ff <= 1'b0;
      pair5_pending_ff <= 1'b0;
      conv_start4_o    <= 1'b0;
      conv_start5_o    <= 1'b0;
      pair4_pending_o  <= 1'b0;
      pair5_pending_o  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      conv_start4_o <= nxt_start4;
      conv_start5_o <= nxt_start5;
      // Trigger wins over completion in the same cycle
      if (trig4) begin
        pair4_pending_ff <= 1'b1;
      end else if (done4) begin
        pair4_pending_ff <= 1'b0;
      end
      if (trig5) begin
        pair5_pending_ff <= 1'b1;
      end else if (done5) begin
        pair5_pending_ff <= 1'b0;
      end
      pair4_pending_o <= trig4 || (pair4_pending_ff && !done4);
      pair5_pending_o <= trig5 || (pair5_pending_ff && !done5);
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  assign irq_events[`APTS_IRQ_DONE4] = done4 && pair4_interrupt_enable_ff;
  assign irq_events[`APTS_IRQ_DONE5] = done5;
  assign nxt_irq_status = irq_events |
                          (irq_status_ff & ~({`APTS_IRQ_W{wr_status}} & wdata_i[`APTS_IRQ_W-1:0]));

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_status_ff <= `APTS_IRQ_RESET;
      irq_o         <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_o         <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  // Read mux, data one cycle after the strobe
  always @* begin
    nxt_rdata = 16'h0000;
    case (addr_i)
      `APTS_REG_CTRL2: begin
        nxt_rdata[`APTS_SRC5_HI:`APTS_SRC5_LO] = pair5_trigger_source_ff;
        nxt_rdata[`APTS_PAIR4_INTERRUPT_ENABLE_BIT]           = pair4_interrupt_enable_ff;
        nxt_rdata[`APTS_PAIR4_PENDING_BIT]            = pair4_pending_ff;
        nxt_rdata[`APTS_PAIR4_SOFTWARE_TRIGGER_BIT]           = pair4_software_trigger_ff;
        nxt_rdata[`APTS_SRC4_HI:`APTS_SRC4_LO] = pair4_trigger_source_ff;
      end
      `APTS_REG_STATUS: begin
        nxt_rdata[`APTS_IRQ_W-1:0] = irq_status_ff;
      end
      `APTS_REG_MASK: begin
        nxt_rdata[`APTS_IRQ_W-1:0] = irq_mask_ff;
      end
      `APTS_REG_PAIR5: begin
        nxt_rdata[`APTS_PEND5_BIT]  = pair5_pending_ff;
        nxt_rdata[`APTS_SWTRG5_BIT] = pair5_software_trigger_ff;
      end
      default: begin
        nxt_rdata = 16'h0000;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      rdata_o <= nxt_rdata;
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // apts_top

`default_nettype wire

/* rtl/apts_trig_mux.v */
`timescale 1ns/1ns
`default_nettype none
`include "apts_defines.vh"

// Registered trigger pick for one pair
module apts_trig_mux (
  input  wire       sys_clk_i,
  input  wire       resetn_i,
  input  wire [4:0] source_i,
  input  wire       sw_trig_i,
  input  wire       special_trig_i,
  input  wire [3:0] pwm_primary_i,
  input  wire [3:0] pwm_secondary_i,
  input  wire [3:0] pwm_climit_i,
  input  wire       tmr1_match_i,
  input  wire       tmr2_match_i,
  output reg        trig_o
);

  wire [4:0] pri_idx = source_i - `APTS_SRC_PRI_LO;
  wire [4:0] sec_idx = source_i - `APTS_SRC_SEC_LO;
  wire [4:0] cl_idx  = source_i - `APTS_SRC_CL_LO;
  reg        nxt_trig;

  always @* begin
    nxt_trig = 1'b0;
    if (source_i == `APTS_SRC_SW_IND || source_i == `APTS_SRC_SW_GLB) begin
      nxt_trig = sw_trig_i;
    end else if (source_i == `APTS_SRC_SPECIAL) begin
      nxt_trig = special_trig_i;
    end else if (source_i >= `APTS_SRC_PRI_LO && source_i <= `APTS_SRC_PRI_HI) begin
      nxt_trig = pwm_primary_i[pri_idx[1:0]];
    end else if (source_i >= `APTS_SRC_SEC_LO && source_i <= `APTS_SRC_SEC_HI) begin
      nxt_trig = pwm_secondary_i[sec_idx[1:0]];
    end else if (source_i >= `APTS_SRC_CL_LO && source_i <= `APTS_SRC_CL_HI) begin
      nxt_trig = pwm_climit_i[cl_idx[1:0]];
    end else if (source_i == `APTS_SRC_TMR1) begin
      nxt_trig = tmr1_match_i;
    end else if (source_i == `APTS_SRC_TMR2) begin
      nxt_trig = tmr2_match_i;
    end
    // Off and reserved codes keep nxt_trig low
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trig_o <= 1'b0;
    end else begin
      trig_o <= nxt_trig;
    end
  end

endmodule // apts_trig_mux

`default_nettype wire

/* verif/apts_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Converter: done pulse a set latency after each start
module apts_conv_model (
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic       other_busy_i,
  input  wire logic [3:0] lat_i,
  output logic            busy_o,
  output logic            done_o
);
  logic [3:0] cnt_ff;

  assign busy_o = other_busy_i;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_ff == 4'h1);
      if (start_i)
        cnt_ff <= lat_i;
      else if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // apts_conv_model
`default_nettype wire

/* verif/apts_top_props.sv */
`timescale 1ns/1ns
`default_nettype none
module apts_top_props (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       wr_i,
  input wire logic       special_trig_i,
  input wire logic [3:0] pwm_primary_i,
  input wire logic [3:0] pwm_secondary_i,
  input wire logic [3:0] pwm_climit_i,
  input wire logic       tmr1_match_i,
  input wire logic       tmr2_match_i,
  input wire logic       conv_busy_i,
  input wire logic       conv_done_i,
  input wire logic       conv_start4_o,
  input wire logic       conv_start5_o,
  input wire logic       pair4_pending_o,
  input wire logic       pair5_pending_o,
  input wire logic       irq_o
);
  logic        own4_ff;
  wire  [15:0] trig_w = {wr_i, special_trig_i, tmr1_match_i, tmr2_match_i, pwm_primary_i, pwm_secondary_i,
                         pwm_climit_i};

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Which pair owns the conversion in flight
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i)
      own4_ff <= 1'b0;
    else if (conv_start4_o || conv_start5_o)
      own4_ff <= conv_start4_o;

  a_reset_quiet: assert property (!$past(resetn_i) |-> {conv_start4_o, conv_start5_o, pair4_pending_o,
    pair5_pending_o, irq_o} == 5'h00) else $error("outputs not clear after reset");
  a_start_not_busy: assert property ((conv_start4_o || conv_start5_o) |-> !$past(conv_busy_i))
    else $error("start while busy");
  a_start_one_pulse: assert property ((conv_start4_o || conv_start5_o) |=> !(conv_start4_o || conv_start5_o))
    else $error("start not a single pulse");
  a_start_exclusive: assert property (!(conv_start4_o && conv_start5_o))
    else $error("both pairs started");
  a_start4_pending: assert property (conv_start4_o |-> pair4_pending_o)
    else $error("pair 4 started without pending");
  a_pair4_first: assert property (conv_start5_o |-> !$past(pair4_pending_o))
    else $error("pair 5 served before pair 4");
  a_done_clears4: assert property (conv_done_i && own4_ff && $past(trig_w) == 16'h0000 && !$past(wr_i, 2)
    && !$past(wr_i, 3) |=> !pair4_pending_o) else $error("pair 4 pending kept after done");
  a_irq_has_cause: assert property ($rose(irq_o) |-> $past(conv_done_i) || $past(conv_done_i, 2)
    || $past(wr_i) || $past(wr_i, 2)) else $error("irq without cause");
endmodule // apts_top_props

bind apts_top apts_top_props i_apts_top_props (.sys_clk_i, .resetn_i, .wr_i, .special_trig_i, .pwm_primary_i,
  .pwm_secondary_i, .pwm_climit_i, .tmr1_match_i, .tmr2_match_i, .conv_busy_i, .conv_done_i, .conv_start4_o,
  .conv_start5_o, .pair4_pending_o, .pair5_pending_o, .irq_o);
`default_nettype wire

/* verif/apts_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module apts_top_tb;
  logic        sys_clk, resetn, wr, rd, busy, done, st4, st5, pd4, pd5, irq, obusy;
  logic [3:0]  addr, lat;
  logic [15:0] wdata, rdata;
  logic [14:0] tv;
  int          mismatches, comparisons, sg;

  apts_top i_apts_top (.sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .special_trig_i(tv[14]), .pwm_primary_i(tv[11:8]), .pwm_secondary_i(tv[7:4]),
    .pwm_climit_i(tv[3:0]), .tmr1_match_i(tv[13]), .tmr2_match_i(tv[12]), .conv_busy_i(busy),
    .conv_done_i(done), .conv_start4_o(st4), .conv_start5_o(st5), .pair4_pending_o(pd4),
    .pair5_pending_o(pd5), .irq_o(irq));
  apts_conv_model i_apts_conv_model (.sys_clk_i(sys_clk), .resetn_i(resetn), .start_i(st4 | st5),
    .other_busy_i(obusy), .lat_i(lat), .busy_o(busy), .done_o(done));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, exp);
  endtask

  task automatic pulse(input logic [14:0] v);
    @(posedge sys_clk);
    tv <= v;
    @(posedge sys_clk);
    tv <= 15'h0000;
  endtask

  // Start order packed one digit per start
  task automatic run(input int n);
    sg = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (st4 === 1'b1) sg = sg * 16 + 4;
      if (st5 === 1'b1) sg = sg * 16 + 5;
    end
  endtask

  // Hardware trigger lines for a source code; all lines for off and reserved codes
  function automatic logic [14:0] trig_of(input int c);
    if (c == 1 || c == 2) return 15'h0000;
    if (c == 3) return 15'h4000;
    if (c >= 4 && c <= 7) return 15'h0100 << (c - 4);
    if (c == 12) return 15'h2000;
    if (c >= 14 && c <= 17) return 15'h0010 << (c - 14);
    if (c >= 23 && c <= 26) return 15'h0001 << (c - 23);
    if (c == 31) return 15'h1000;
    return 15'h7fff;
  endfunction

  initial begin
    #200000;
    mismatches++;
    final_report;
  end

  initial begin
    {wr, rd, obusy} = 3'b000;
    addr = 4'h0;
    wdata = 16'h0000;
    tv = 15'h0000;
    lat = 4'h3;
    mismatches = 0;
    comparisons = 0;
    resetn = 1'b0;
    void'($urandom(32'h7c945f23));
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) rdc(4'(a), 16'h0000);
    for (int p = 4; p <= 5; p++) begin
      for (int c = 0; c < 32; c++) begin
        @(posedge sys_clk);
        lat <= 4'(1 + $urandom % 6);
        wrr(4'h0, p == 4 ? 16'(c) : 16'(c << 8));
        pulse(15'h7fff ^ trig_of(c));
        if (c == 1 || c == 2) wrr(p == 4 ? 4'h0 : 4'h3, p == 4 ? 16'(c) | 16'h0020 : 16'h0002);
        else pulse(trig_of(c));
        run(24);
        chk(sg[15:0], trig_of(c) != 15'h7fff ? 16'(p) : 16'h0000);
        chk(16'({pd4, pd5}), 16'h0000);
        rdc(p == 4 ? 4'h0 : 4'h3, p == 4 ? 16'(c) : 16'h0000);
      end
    end
    rdc(4'h1, 16'h0002);
    wrr(4'h1, 16'h0002);
    // Enable and mask combinations of the pair 4 completion interrupt
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      obusy <= 1'b1;
      wrr(4'h2, 16'(k != 1));
      wrr(4'h0, k < 2 ? 16'h0082 : 16'h0002);
      wrr(4'h0, k < 2 ? 16'h00a2 : 16'h0022);
      run(6);
      chk(sg[15:0], 16'h0000);
      rdc(4'h0, k < 2 ? 16'h00c2 : 16'h0042);
      chk(16'(pd4), 16'h0001);
      @(posedge sys_clk);
      obusy <= 1'b0;
      run(16);
      chk(sg[15:0], 16'h0004);
      chk(16'(irq), 16'(k == 0));
      rdc(4'h1, 16'(k < 2));
      wrr(4'h1, 16'h0001);
      rdc(4'h1, 16'h0000);
      chk(16'(irq), 16'h0000);
    end
    @(posedge sys_clk);
    obusy <= 1'b1;
    wrr(4'h0, 16'h0c0c);
    pulse(15'h2000);
    run(4);
    rdc(4'h3, 16'h0001);
    rdc(4'h0, 16'h0c4c);
    chk(16'({pd4, pd5}), 16'h0003);
    @(posedge sys_clk);
    obusy <= 1'b0;
    run(30);
    chk(sg[15:0], 16'h0045);
    wrr(4'h9, 16'hffff);
    rdc(4'h9, 16'h0000);
    rdc(4'h0, 16'h0c0c);
    // Reset again in mid-run
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    rdc(4'h0, 16'h0000);
    rdc(4'h1, 16'h0000);
    final_report;
  end
endmodule // apts_top_tb
`default_nettype wire
